// ==== include/ota_params.svh ====
/*
 * Constants of the over-temperature alert block: APB offsets, config bit
 * positions, reset values and serial addresses.
 * Assumes inclusion by the design modules and the test bench.
 */
`ifndef OTA_PARAMS_SVH
`define OTA_PARAMS_SVH
`define OTA_ADDR_CFG 8'h00
`define OTA_ADDR_TOS 8'h04
`define OTA_ADDR_THYST 8'h08
`define OTA_ADDR_STAT 8'h0c
`define OTA_ADDR_TEMP 8'h10
`define OTA_ADDR_ISTAT 8'h14
`define OTA_ADDR_IMASK 8'h18
`define OTA_CFG_SHDN_BIT 0
`define OTA_CFG_INT_BIT 1
`define OTA_CFG_POL_BIT 2
`define OTA_CFG_SMB_BIT 7
`define OTA_IRQ_ALERT_BIT 0
`define OTA_IRQ_WON_BIT 1
`define OTA_IRQ_LOST_BIT 2
`define OTA_RST_TOS 16'h5000
`define OTA_RST_THYST 16'h4b00
`define OTA_RST_IMASK 3'h0
`define OTA_ARA_ADDR 7'h0c
`define OTA_DEV_ADDR_HI 4'h9
`endif

// ==== include/ota_pkg.sv ====
/*
 * Types of the over-temperature alert block.
 * Assumes ota_params.svh on the include path.
 */
package ota_pkg;
    typedef struct packed {
        logic smbusAlertEnable;
        logic polarityHigh;
        logic interruptMode;
        logic shutdown;
    } ota_cfg_t;

    typedef enum logic [2:0] {
        ARA_IDLE = 3'b000,
        ARA_ADDR = 3'b001,
        ARA_ADEC = 3'b010,
        ARA_ACKA = 3'b011,
        ARA_DATA = 3'b100,
        ARA_DEND = 3'b101,
        ARA_MACK = 3'b110
    } ota_ara_state_t;
endpackage : ota_pkg

// ==== verilog/ota_ara_responder.sv ====
/*
 * Alert response address answerer: watches SCL/SDA, acknowledges a read of
 * the alert response address while armed and sends the response byte.
 * Assumes pins are asynchronous and bit rate is far below clk_sys.
 */
`timescale 1ns/1ps
`include "ota_params.svh"
module ota_ara_responder
    import ota_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // Serial bus pins
    input wire logic sclPin,
    input wire logic sdaPin,
    output logic sdaOut,
    output logic sdaOe,
    // Alert side
    input wire logic armed,
    input wire logic [7:0] respByte,
    output logic araWon,
    output logic araLost
);
ota_ara_state_t state_reg;
logic sclMeta_reg, sclSync_reg, sclPrev_reg;
logic sdaMeta_reg, sdaSync_reg, sdaPrev_reg;
logic [2:0] cnt_reg;
logic [7:0] shift_reg;
logic sdaOe_reg, won_reg, lost_reg;
logic sclRise, sclFall, startCond, stopCond;

always_ff @(posedge clk_sys) begin
    if (!nrst) begin
        {sclMeta_reg, sclSync_reg, sclPrev_reg} <= 3'h7;
        {sdaMeta_reg, sdaSync_reg, sdaPrev_reg} <= 3'h7;
    end else begin
        {sclMeta_reg, sclSync_reg, sclPrev_reg} <= {sclPin, sclMeta_reg, sclSync_reg};
        {sdaMeta_reg, sdaSync_reg, sdaPrev_reg} <= {sdaPin, sdaMeta_reg, sdaSync_reg};
    end
end

assign sclRise = sclSync_reg & ~sclPrev_reg;
assign sclFall = ~sclSync_reg & sclPrev_reg;
assign startCond = sclSync_reg & sclPrev_reg & ~sdaSync_reg & sdaPrev_reg;
assign stopCond = sclSync_reg & sclPrev_reg & sdaSync_reg & ~sdaPrev_reg;

always_ff @(posedge clk_sys) begin
    if (!nrst) begin
        state_reg <= ARA_IDLE;
        cnt_reg <= 3'h0;
        shift_reg <= 8'h00;
        sdaOe_reg <= 1'b0;
        won_reg <= 1'b0;
        lost_reg <= 1'b0;
    end else begin
        won_reg <= 1'b0;
        lost_reg <= 1'b0;
        if (startCond) begin
            state_reg <= ARA_ADDR;
            cnt_reg <= 3'h0;
            sdaOe_reg <= 1'b0;
        end else if (stopCond) begin
            state_reg <= ARA_IDLE;
            sdaOe_reg <= 1'b0;
        end else begin
            case (state_reg)
                ARA_ADDR: if (sclRise) begin
                    shift_reg <= {shift_reg[6:0], sdaSync_reg};
                    cnt_reg <= 3'(cnt_reg + 3'h1);
                    if (cnt_reg == 3'h7) state_reg <= ARA_ADEC;
                end
                ARA_ADEC: if (sclFall) begin
                    if (shift_reg == {`OTA_ARA_ADDR, 1'b1} && armed) begin
                        sdaOe_reg <= 1'b1;
                        state_reg <= ARA_ACKA;
                    end else begin
                        state_reg <= ARA_IDLE;
                    end
                end
                ARA_ACKA: if (sclFall) begin
                    shift_reg <= respByte;
                    sdaOe_reg <= ~respByte[7];
                    cnt_reg <= 3'h0;
                    state_reg <= ARA_DATA;
                end
                ARA_DATA: if (sclRise) begin
                    if (!sdaOe_reg && !sdaSync_reg) begin
                        lost_reg <= 1'b1;
                        state_reg <= ARA_IDLE;
                    end else begin
                        cnt_reg <= 3'(cnt_reg + 3'h1);
                        if (cnt_reg == 3'h7) state_reg <= ARA_DEND;
                    end
                end else if (sclFall) begin
                    shift_reg <= {shift_reg[6:0], 1'b0};
                    sdaOe_reg <= ~shift_reg[6];
                end
                ARA_DEND: if (sclFall) begin
                    sdaOe_reg <= 1'b0;
                    state_reg <= ARA_MACK;
                end
                ARA_MACK: if (sclRise) begin
                    won_reg <= 1'b1;
                    state_reg <= ARA_IDLE;
                end
                default: state_reg <= ARA_IDLE;
            endcase
        end
    end
end

assign sdaOut = 1'b0;
assign sdaOe = sdaOe_reg;
assign araWon = won_reg;
assign araLost = lost_reg;

default clocking cb @(posedge clk_sys); endclocking
default disable iff (!nrst);

AST_ARA_ACK: assert property (state_reg == ARA_ADEC && sclFall && !startCond && !stopCond && armed
    && shift_reg == {`OTA_ARA_ADDR, 1'b1} |=> sdaOe_reg && state_reg == ARA_ACKA)
    else $error("alert response address not acknowledged");
AST_ARA_SILENT: assert property (!armed && state_reg == ARA_ADEC |=> !sdaOe_reg)
    else $error("acknowledged while not armed");
COV_ARA_WON: cover property (state_reg == ARA_MACK ##[1:1000] won_reg);
endmodule : ota_ara_responder

// ==== verilog/ota_alert_top.sv ====
/*
 * Over-temperature alert logic: limit compare, comparator and interrupt
 * modes, open-drain alert pin, alert response answer, APB registers, irq.
 * Assumes tempValid/tempData come from the converter on clk_sys; the serial
 * pins and address straps are asynchronous.
 */
// Register access over APB and the register addresses were left to the implementer.
// Functional notes
// - Alert asserts when a sample exceeds the over-temperature limit.
// - After reset comparator mode is selected; pin is a plain alert.
// - Comparator mode: alert releases when temperature falls below hysteresis limit.
// - Comparator mode: entering shutdown keeps the alert state.
// - Interrupt mode: any register read releases the alert; the code releases it only on reads of CFG, TOS, THYST, STAT and TEMP.
// - Interrupt mode: after an over event, re-alert only below hysteresis.
// - Interrupt mode: after an under event, re-alert only above limit.
// - With SMBus alert enabled, answering the response address clears alert.
// - Interrupt mode: entering shutdown clears the alert.
// - SMBus alert answering only when the enable bit is one.
// - Alert pin is open-drain; active-low for wired-AND sharing.
// - While alerting, acknowledge response address read and return own address.
// - Response LSB one for over-limit event, zero for under-hysteresis event.
// - Arbitration loss keeps the alert asserted; lowest address wins.
// - After a successful answer the alert is released.
`timescale 1ns/1ps
`include "ota_params.svh"
module ota_alert_top
    import ota_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Converter samples
    input wire logic tempValid,
    input wire logic [15:0] tempData,
    // Address straps
    input wire logic [2:0] addrPins,
    // Serial bus pins
    input wire logic sclIn,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe,
    // Alert pin
    output logic alertPinOut,
    output logic alertPinOe,
    // Interrupt
    output logic irq
);
////////////////////////////////////////////////////////////////////////////////
ota_cfg_t cfg_reg;
logic [15:0] tos_reg, thyst_reg, lastTemp_reg;
logic [2:0] irqStat_reg, irqMask_reg, irqStat_next;
logic [31:0] prdata_reg, rdMux;
logic pready_reg, pslverr_reg, irq_reg;
logic alertAct_reg, alertAct_next, armOver_reg, armOver_next, lsb_reg, lsb_next;
logic prevShdn_reg, alertPinOe_reg, alertPinOut_reg;
logic [2:0] addrMeta_reg, addrSync_reg;
logic setupPh, accessPh, wrEv, rdEv, addrHit;
logic sample, tempOver, tempUnder, setEv, clrBase, clearEv, shdnEntry, modeChg;
logic araArmed, araWon, araLost;
logic [7:0] respByte;

////////////////////////////////////////////////////////////////////////////////
// APB handshake: zero wait states, data captured in the setup cycle
assign setupPh = psel & ~penable;
assign accessPh = psel & penable & pready_reg;
assign wrEv = accessPh & pwrite;
assign rdEv = accessPh & ~pwrite & (paddr == `OTA_ADDR_CFG || paddr == `OTA_ADDR_TOS
    || paddr == `OTA_ADDR_THYST || paddr == `OTA_ADDR_TEMP || paddr == `OTA_ADDR_STAT);

always_comb begin
    addrHit = 1'b1;
    rdMux = 32'h0000_0000;
    if (paddr == `OTA_ADDR_CFG) begin
        rdMux[`OTA_CFG_SMB_BIT] = cfg_reg.smbusAlertEnable;
        rdMux[`OTA_CFG_POL_BIT] = cfg_reg.polarityHigh;
        rdMux[`OTA_CFG_INT_BIT] = cfg_reg.interruptMode;
        rdMux[`OTA_CFG_SHDN_BIT] = cfg_reg.shutdown;
    end else if (paddr == `OTA_ADDR_TOS) begin
        rdMux[15:0] = tos_reg;
    end else if (paddr == `OTA_ADDR_THYST) begin
        rdMux[15:0] = thyst_reg;
    end else if (paddr == `OTA_ADDR_STAT) begin
        rdMux[2:0] = {lsb_reg, armOver_reg, alertAct_reg};
    end else if (paddr == `OTA_ADDR_TEMP) begin
        rdMux[15:0] = lastTemp_reg;
    end else if (paddr == `OTA_ADDR_ISTAT) begin
        rdMux[2:0] = irqStat_reg;
    end else if (paddr == `OTA_ADDR_IMASK) begin
        rdMux[2:0] = irqMask_reg;
    end else begin
        addrHit = 1'b0;
    end
end

always_ff @(posedge clk_sys) begin
    if (!nrst) begin
        pready_reg <= 1'b0;
        pslverr_reg <= 1'b0;
        prdata_reg <= 32'h0000_0000;
    end else begin
        pready_reg <= setupPh;
        pslverr_reg <= setupPh & ~addrHit;
        if (setupPh) prdata_reg <= pwrite ? 32'h0000_0000 : rdMux;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Software-written registers
always_ff @(posedge clk_sys) begin
    if (!nrst) begin
        cfg_reg <= '0;
        tos_reg <= `OTA_RST_TOS;
        thyst_reg <= `OTA_RST_THYST;
        irqMask_reg <= `OTA_RST_IMASK;
    end else if (wrEv) begin
        if (paddr == `OTA_ADDR_CFG) begin
            cfg_reg.smbusAlertEnable <= pwdata[`OTA_CFG_SMB_BIT];
            cfg_reg.polarityHigh <= pwdata[`OTA_CFG_POL_BIT];
            cfg_reg.interruptMode <= pwdata[`OTA_CFG_INT_BIT];
            cfg_reg.shutdown <= pwdata[`OTA_CFG_SHDN_BIT];
        end else if (paddr == `OTA_ADDR_TOS) begin
            tos_reg <= pwdata[15:0];
        end else if (paddr == `OTA_ADDR_THYST) begin
            thyst_reg <= pwdata[15:0];
        end else if (paddr == `OTA_ADDR_IMASK) begin
            irqMask_reg <= pwdata[2:0];
        end
    end
end

assign modeChg = wrEv & (paddr == `OTA_ADDR_CFG) & (pwdata[`OTA_CFG_INT_BIT] != cfg_reg.interruptMode);

////////////////////////////////////////////////////////////////////////////////
// Limit compare and alert state
assign sample = tempValid & ~cfg_reg.shutdown;
assign tempOver = $signed(tempData) > $signed(tos_reg);
assign tempUnder = $signed(tempData) < $signed(thyst_reg);
assign shdnEntry = cfg_reg.shutdown & ~prevShdn_reg;
assign setEv = sample & cfg_reg.interruptMode & (armOver_reg ? tempOver : tempUnder);
assign clrBase = cfg_reg.interruptMode & (rdEv | shdnEntry);
assign clearEv = clrBase | (cfg_reg.smbusAlertEnable & araWon);

always_comb begin
    alertAct_next = alertAct_reg;
    armOver_next = armOver_reg;
    lsb_next = lsb_reg;
    if (modeChg) begin
        alertAct_next = 1'b0;
        armOver_next = 1'b1;
    end else if (!cfg_reg.interruptMode) begin
        if (sample && tempOver) begin
            alertAct_next = 1'b1;
            lsb_next = 1'b1;
        end else if (sample && tempUnder) begin
            alertAct_next = 1'b0;
            lsb_next = 1'b0;
        end else if (clearEv) begin
            alertAct_next = 1'b0;
        end
        // Between the limits and in shutdown only clearEv (an answered response) clears the alert
    end else if (setEv) begin
        alertAct_next = 1'b1;
        armOver_next = ~armOver_reg;
        lsb_next = armOver_reg;
    end else if (clearEv) begin
        alertAct_next = 1'b0;
    end
end

always_ff @(posedge clk_sys) begin
    if (!nrst) begin
        alertAct_reg <= 1'b0;
        armOver_reg <= 1'b1;
        lsb_reg <= 1'b0;
        prevShdn_reg <= 1'b0;
        lastTemp_reg <= 16'h0000;
    end else begin
        alertAct_reg <= alertAct_next;
        armOver_reg <= armOver_next;
        lsb_reg <= lsb_next;
        prevShdn_reg <= cfg_reg.shutdown;
        if (sample) lastTemp_reg <= tempData;
    end
end

// Open-drain: pull low when the logical alert differs from the polarity bit
always_ff @(posedge clk_sys) begin
    if (!nrst) begin
        alertPinOe_reg <= 1'b0;
        alertPinOut_reg <= 1'b0;
    end else begin
        alertPinOe_reg <= alertAct_reg ^ cfg_reg.polarityHigh;
        alertPinOut_reg <= 1'b0;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Alert response address answer
always_ff @(posedge clk_sys) begin
    if (!nrst) begin
        addrMeta_reg <= 3'h0;
        addrSync_reg <= 3'h0;
    end else begin
        addrMeta_reg <= addrPins;
        addrSync_reg <= addrMeta_reg;
    end
end

assign araArmed = cfg_reg.smbusAlertEnable & alertAct_reg;
assign respByte = {`OTA_DEV_ADDR_HI, addrSync_reg, lsb_reg};

ota_ara_responder uAra (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .sclPin(sclIn),
    .sdaPin(sdaIn),
    .sdaOut(sdaOut),
    .sdaOe(sdaOe),
    .armed(araArmed),
    .respByte(respByte),
    .araWon(araWon),
    .araLost(araLost)
);

////////////////////////////////////////////////////////////////////////////////
// Sticky event bits, write one to clear, set wins
always_comb begin
    irqStat_next = irqStat_reg;
    if (wrEv && paddr == `OTA_ADDR_ISTAT) irqStat_next = irqStat_reg & ~pwdata[2:0];
    if (alertAct_next && !alertAct_reg) irqStat_next[`OTA_IRQ_ALERT_BIT] = 1'b1;
    if (araWon) irqStat_next[`OTA_IRQ_WON_BIT] = 1'b1;
    if (araLost) irqStat_next[`OTA_IRQ_LOST_BIT] = 1'b1;
end

always_ff @(posedge clk_sys) begin
    if (!nrst) begin
        irqStat_reg <= 3'h0;
        irq_reg <= 1'b0;
    end else begin
        irqStat_reg <= irqStat_next;
        irq_reg <= |(irqStat_next & irqMask_reg);
    end
end

assign prdata = prdata_reg;
assign pready = pready_reg;
assign pslverr = pslverr_reg;
assign alertPinOut = alertPinOut_reg;
assign alertPinOe = alertPinOe_reg;
assign irq = irq_reg;

////////////////////////////////////////////////////////////////////////////////
default clocking cb @(posedge clk_sys); endclocking
default disable iff (!nrst);

AST_CMP_SET: assert property (!cfg_reg.interruptMode && sample && tempOver && !modeChg |=> alertAct_reg)
    else $error("comparator alert not set above limit");
AST_POWERUP: assert property ($rose(nrst) |-> !cfg_reg.interruptMode && !alertAct_reg)
    else $error("not in comparator mode after reset");
AST_CMP_CLR: assert property (!cfg_reg.interruptMode && sample && tempUnder && !tempOver && !modeChg
    |=> !alertAct_reg)
    else $error("comparator alert not released below hysteresis");
AST_CMP_SHDN: assert property (!cfg_reg.interruptMode && shdnEntry && !araWon && !modeChg
    |=> alertAct_reg == $past(alertAct_reg))
    else $error("shutdown changed comparator alert");
AST_INT_RDCLR: assert property (cfg_reg.interruptMode && rdEv && !setEv && !modeChg |=> !alertAct_reg)
    else $error("register read did not clear alert");
AST_INT_UNDER: assert property (cfg_reg.interruptMode && !alertAct_reg && !armOver_reg && !modeChg
    ##1 alertAct_reg |-> $past(sample) && $past(tempUnder))
    else $error("interrupt alert set without under-hysteresis sample");
AST_INT_OVER: assert property (cfg_reg.interruptMode && !alertAct_reg && armOver_reg && !modeChg
    ##1 alertAct_reg |-> $past(sample) && $past(tempOver))
    else $error("interrupt alert set without over-limit sample");
AST_ARA_CLR: assert property (cfg_reg.smbusAlertEnable && araWon && !setEv && !modeChg
    && !(sample && tempOver) |=> !alertAct_reg)
    else $error("alert not cleared after response");
AST_INT_SHDN: assert property (cfg_reg.interruptMode && shdnEntry && !modeChg |=> !alertAct_reg)
    else $error("shutdown did not clear interrupt alert");
AST_ARA_GATE: assert property (!cfg_reg.smbusAlertEnable |-> !araArmed && !sdaOe)
    else $error("alert response enabled without enable bit");
AST_PIN_POL: assert property (!cfg_reg.polarityHigh && alertAct_reg ##1 !cfg_reg.polarityHigh
    |-> alertPinOe && !alertPinOut)
    else $error("active-low alert pin not pulled low");
AST_LSB: assert property (!cfg_reg.interruptMode && sample && tempOver && !modeChg |=> lsb_reg
    ##0 respByte[0])
    else $error("response LSB not set for over-limit event");
AST_ARA_LOST: assert property (araLost && !sample && !clrBase && !modeChg
    |=> alertAct_reg == $past(alertAct_reg))
    else $error("arbitration loss changed alert");
AST_CMP_HOLD: assert property (!cfg_reg.interruptMode && alertAct_reg && sample && !tempOver && !tempUnder
    && !araWon && !modeChg |=> alertAct_reg)
    else $error("comparator alert dropped between limits");
// Interrupt re-arm, response byte, comparator shutdown, pin level and status bits
AST_INT_SET_UNDER: assert property (cfg_reg.interruptMode && sample && !armOver_reg
    && tempUnder && !modeChg |=> alertAct_reg)
    else $error("interrupt alert not set below hysteresis");
AST_INT_HOLD_UNDER: assert property (cfg_reg.interruptMode && !alertAct_reg && !armOver_reg
    && !tempUnder && !modeChg |=> !alertAct_reg)
    else $error("interrupt alert set above hysteresis");
AST_INT_SET_OVER: assert property (cfg_reg.interruptMode && sample && armOver_reg
    && tempOver && !modeChg |=> alertAct_reg)
    else $error("interrupt alert not set above limit");
AST_INT_HOLD_OVER: assert property (cfg_reg.interruptMode && !alertAct_reg && armOver_reg
    && !tempOver && !modeChg |=> !alertAct_reg)
    else $error("interrupt alert set below limit");
AST_INT_LSB: assert property (cfg_reg.interruptMode && setEv && !modeChg
    |=> lsb_reg == $past(armOver_reg))
    else $error("interrupt response LSB wrong");
AST_CMP_LSB_LOW: assert property (!cfg_reg.interruptMode && sample && tempUnder && !tempOver
    && !modeChg |=> !lsb_reg)
    else $error("response LSB not cleared below hysteresis");
AST_CMP_SHDN_KEEP: assert property (!cfg_reg.interruptMode && cfg_reg.shutdown && !araWon
    && !modeChg |=> alertAct_reg == $past(alertAct_reg))
    else $error("comparator alert changed in shutdown");
AST_PIN_RELEASE: assert property (cfg_reg.smbusAlertEnable && !cfg_reg.polarityHigh && araWon
    && !sample && !modeChg ##1 !cfg_reg.polarityHigh |=> !alertPinOe)
    else $error("alert pin not released after response");
AST_PIN_HIGH: assert property (cfg_reg.polarityHigh && !alertAct_reg ##1 cfg_reg.polarityHigh
    |-> alertPinOe && !alertPinOut)
    else $error("active-high alert pin not pulled low when idle");
AST_IRQ_WON: assert property (araWon
    |=> irqStat_reg[`OTA_IRQ_WON_BIT])
    else $error("answered status bit not set");
AST_IRQ_LOST: assert property (araLost
    |=> irqStat_reg[`OTA_IRQ_LOST_BIT])
    else $error("arbitration lost status bit not set");

COV_INT_CYCLE: cover property (cfg_reg.interruptMode && setEv ##[1:1000] rdEv ##[1:1000] setEv);
COV_ARA_ANSWER: cover property (araArmed ##[1:1000] araWon);
COV_ARA_LOST: cover property (araArmed ##[1:1000] araLost);
endmodule : ota_alert_top

// ==== tb/ota_smbus_master.sv ====
/*
 * Bus master model: drives the serial clock and data lines and reads the
 * alert response address, with an optional rival device on the data line.
 * Assumes pull-ups on both lines and open-drain data drive by the device.
 */
`timescale 1ns/1ps
module ota_smbus_master (
    // Clock
    input wire logic clk_sys,
    // Device data drive
    input wire logic sdaOe,
    // Bus lines
    output logic sclLine,
    output logic sdaLine
);
    ////////////////////////////////////////////////////////////////////////
    localparam logic [7:0] ARA_READ = 8'h19;
    logic sdaDrv = 1'b1;
    initial sclLine = 1'b1;
    // Wired-AND with pull-up: released line reads high
    assign sdaLine = sdaDrv & ~sdaOe;

    ////////////////////////////////////////////////////////////////////////
    // One bit: data changes in the low half, sampled at the end of the high half
    task automatic clk_bit(input logic b, output logic r);
        sclLine <= 1'b0;
        repeat (2) @(posedge clk_sys);
        sdaDrv <= b;
        repeat (2) @(posedge clk_sys);
        sclLine <= 1'b1;
        repeat (4) @(posedge clk_sys);
        r = sdaLine;
    endtask : clk_bit

    task automatic ara(input logic [7:0] rival, output logic ack, output logic [7:0] rx);
        logic r;
        @(posedge clk_sys);
        sdaDrv <= 1'b0;
        repeat (4) @(posedge clk_sys);
        for (int i = 7; i >= 0; i--) begin
            clk_bit(ARA_READ[i], r);
        end
        clk_bit(1'b1, r);
        ack = ~r;
        // Rival bits model a second answering device
        for (int i = 7; i >= 0; i--) begin
            clk_bit(rival[i], r);
            rx[i] = r;
        end
        clk_bit(1'b1, r);
        clk_bit(1'b0, r);
        sdaDrv <= 1'b1;
        repeat (4) @(posedge clk_sys);
    endtask : ara
endmodule : ota_smbus_master

// ==== tb/ota_alert_top_test.sv ====
/*
 * Self-checking bench: APB register access, converter samples and alert
 * response reads through the bus master model.
 * Assumes the design's zero-wait APB slave and 25 MHz clock.
 */
`timescale 1ns/1ps
`include "ota_params.svh"
module ota_alert_top_test;
    logic clk_sys = 1'b0;
    logic nrst = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, sdaOut, sdaOe, alertPinOut, alertPinOe, irq, sclLine, sdaLine;
    logic tempValid = 1'b0;
    logic [15:0] tempData = 16'h0000;
    logic [31:0] rd;
    logic e;
    int n_mismatch = 0;
    int cmp_count = 0;

    always #20 clk_sys = ~clk_sys;

    ota_alert_top dut (.clk_sys(clk_sys), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .tempValid(tempValid), .tempData(tempData), .addrPins(3'b101), .sclIn(sclLine), .sdaIn(sdaLine),
        .sdaOut(sdaOut), .sdaOe(sdaOe), .alertPinOut(alertPinOut), .alertPinOe(alertPinOe), .irq(irq));
    ota_smbus_master master (.clk_sys(clk_sys), .sdaOe(sdaOe), .sclLine(sclLine), .sdaLine(sdaLine));

    ////////////////////////////////////////////////////////////////////////
    task automatic end_sim;
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : end_sim

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rdat, output logic err);
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk_sys);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys);
        end while (pready !== 1'b1);
        rdat = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, rd, e);
    endtask : wr

    task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0, rd, e);
        chk(nm, exp, rd);
    endtask : rdchk

    task automatic sample(input logic [15:0] t);
        @(posedge clk_sys);
        tempData <= t;
        tempValid <= 1'b1;
        @(posedge clk_sys);
        tempValid <= 1'b0;
    endtask : sample

    task automatic lvl(input logic ePin, input logic eIrq);
        repeat (4) @(posedge clk_sys);
        chk("alert pin", {31'h0, ePin}, {31'h0, alertPinOe});
        chk("irq", {31'h0, eIrq}, {31'h0, irq});
        chk("alert out", 32'h0, {31'h0, alertPinOut});
    endtask : lvl

    task automatic arachk(input logic [7:0] rival, input logic eAck, input logic [7:0] eRx);
        logic a;
        logic [7:0] rx;
        master.ara(rival, a, rx);
        chk("ara ack", {31'h0, eAck}, {31'h0, a});
        chk("ara byte", {24'h0, eRx}, {24'h0, rx});
        chk("sda out", 32'h0, {31'h0, sdaOut});
    endtask : arachk

    ////////////////////////////////////////////////////////////////////////
    initial begin
        #400000;
        n_mismatch++;
        end_sim();
    end

    initial begin
        repeat (12) @(posedge clk_sys);
        nrst <= 1'b1;
        rdchk("cfg", `OTA_ADDR_CFG, 32'h0);
        rdchk("tos", `OTA_ADDR_TOS, 32'h5000);
        rdchk("thyst", `OTA_ADDR_THYST, 32'h4b00);
        rdchk("imask", `OTA_ADDR_IMASK, 32'h0);
        apb(1'b0, 8'h1c, 32'h0, rd, e);
        chk("slverr", 32'h1, {31'h0, e});
        lvl(1'b0, 1'b0);
        // Comparator mode
        sample(16'h5100);
        lvl(1'b1, 1'b0);
        sample(16'h4c00);
        lvl(1'b1, 1'b0);
        wr(`OTA_ADDR_CFG, 32'h1);
        sample(16'h4000);
        lvl(1'b1, 1'b0);
        wr(`OTA_ADDR_CFG, 32'h0);
        sample(16'h4000);
        lvl(1'b0, 1'b0);
        wr(`OTA_ADDR_CFG, 32'h4);
        lvl(1'b1, 1'b0);
        // Interrupt mode
        wr(`OTA_ADDR_CFG, 32'h2);
        sample(16'h5100);
        lvl(1'b1, 1'b0);
        rdchk("temp", `OTA_ADDR_TEMP, 32'h5100);
        lvl(1'b0, 1'b0);
        sample(16'h5200);
        lvl(1'b0, 1'b0);
        sample(16'h4000);
        lvl(1'b1, 1'b0);
        rdchk("tos", `OTA_ADDR_TOS, 32'h5000);
        lvl(1'b0, 1'b0);
        sample(16'h4000);
        lvl(1'b0, 1'b0);
        sample(16'h5100);
        lvl(1'b1, 1'b0);
        wr(`OTA_ADDR_CFG, 32'h3);
        lvl(1'b0, 1'b0);
        // Alert response with interrupt enabled
        wr(`OTA_ADDR_IMASK, 32'h7);
        wr(`OTA_ADDR_ISTAT, 32'h7);
        wr(`OTA_ADDR_CFG, 32'h0);
        wr(`OTA_ADDR_CFG, 32'h82);
        sample(16'h5100);
        lvl(1'b1, 1'b1);
        arachk(8'hff, 1'b1, 8'h9b);
        lvl(1'b0, 1'b1);
        rdchk("istat", `OTA_ADDR_ISTAT, 32'h3);
        wr(`OTA_ADDR_ISTAT, 32'h7);
        lvl(1'b0, 1'b0);
        sample(16'h4000);
        lvl(1'b1, 1'b1);
        arachk(8'hff, 1'b1, 8'h9a);
        lvl(1'b0, 1'b1);
        wr(`OTA_ADDR_ISTAT, 32'h7);
        // Lost arbitration, then repeated read
        sample(16'h5100);
        lvl(1'b1, 1'b1);
        arachk(8'h90, 1'b1, 8'h90);
        lvl(1'b1, 1'b1);
        rdchk("istat", `OTA_ADDR_ISTAT, 32'h5);
        arachk(8'hff, 1'b1, 8'h9b);
        lvl(1'b0, 1'b1);
        // Alert response disabled, interrupt masked
        wr(`OTA_ADDR_ISTAT, 32'h7);
        wr(`OTA_ADDR_IMASK, 32'h0);
        wr(`OTA_ADDR_CFG, 32'h2);
        sample(16'h4000);
        lvl(1'b1, 1'b0);
        arachk(8'hff, 1'b0, 8'hff);
        lvl(1'b1, 1'b0);
        rdchk("istat", `OTA_ADDR_ISTAT, 32'h1);
        end_sim();
    end
endmodule : ota_alert_top_test
